// ===== design/prs_consts.vh
// Constants for the pixel readout sequencer and black level servo.
// Assumes a 32-bit AXI4-Lite register bus and 10-bit pixel codes.
`ifndef PRS_CONSTS_VH
`define PRS_CONSTS_VH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define PRS_A_CTRL 5'h00
`define PRS_A_ORIG 5'h04
`define PRS_A_BLK 5'h08
`define PRS_A_GAIN 5'h0c
`define PRS_A_STAT 5'h10
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PRS_CTRL_RST 7'h41
`define PRS_BLK_RST 7'h24
`define PRS_GAIN_RST 8'hf0
// Accumulator default: offset -64 with 8 fraction bits
`define PRS_ACC_RST 19'h7c000
`define PRS_FRAC 8
// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define PRS_B_HSHUF 0
`define PRS_B_MIRR 1
`define PRS_B_VSHUF 2
`define PRS_B_FLIP 3
`define PRS_B_STBY 6
`define PRS_M_FULL 2'h0
`define PRS_M_CROP 2'h1
`define PRS_M_SUB 2'h2
`define PRS_C_NONE 2'h0
`define PRS_C_INT 2'h1
`define PRS_C_EXT 2'h2
// ----------------------------------------------------------------
// Geometry (1-based physical addresses)
// ----------------------------------------------------------------
`define PRS_FULL_W 9'h164
`define PRS_FULL_H 9'h124
`define PRS_QTR_W 9'h0b4
`define PRS_QTR_H 9'h094
`define PRS_FULL_X 9'h005
`define PRS_FULL_Y 9'h005
`define PRS_SUB_X 9'h001
`define PRS_SUB_Y 9'h005
`define PRS_XMIN 9'h001
`define PRS_XMAX 9'h0b9
`define PRS_YMIN 9'h005
`define PRS_YMAX 9'h095
`define PRS_XCTR 9'h05d
`define PRS_YCTR 9'h04d
`define PRS_BLK_LINES 9'h004
`define PRS_BLK_SAMP 9'h080
// ----------------------------------------------------------------
// Servo and clock figures
// ----------------------------------------------------------------
`define PRS_TARGET 11'h080
`define PRS_BAND_N 11'h002
`define PRS_BAND_W 11'h004
`define PRS_DIV_FULL 3'h3
`define PRS_DIV_QTR 3'h7
`define PRS_PIX_MAX 12'h3ff
`endif

// ===== design/prs_top.v
// Pixel readout sequencer with black level servo and AXI4-Lite registers.
// Assumes the pixel array answers pix_data on the same clock, valid by
// the next pixel tick after an address is issued.
`timescale 1ns/1ns
`include "prs_consts.vh"
`default_nettype none
module prs_top
(
  input wire aclk,
  input wire aresetn,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [8:0] pix_col,
  output reg [8:0] pix_row,
  output reg pix_rd,
  input wire [9:0] pix_data,
  output reg [9:0] vid_data,
  output reg vid_valid,
  output reg vid_sol,
  output reg vid_sof
);
  // ----------------------------------------------------------------
  // Address order helper
  // ----------------------------------------------------------------
  // Maps a sequence index to a window offset under shuffle and reverse
  function [8:0] fn_order;
    input [8:0] i;
    input [8:0] n;
    input shuf;
    input rev;
    reg [8:0] k;
    reg [8:0] half;
    begin
      half = n >> 1;
      k = i;
      if (shuf)
        k = (i < half) ? ((i << 1) | 9'h001) : ((i - half) << 1);
      if (rev)
        k = n - 9'h001 - k;
      fn_order = k;
    end
  endfunction
  // Keeps pairs of pixels, skipping the next pair
  function [8:0] fn_sub;
    input [8:0] k;
    begin
      fn_sub = {k[7:1], 1'b0, k[0]};
    end
  endfunction
  // Clamps an origin into its legal range
  function [8:0] fn_lim;
    input [8:0] v;
    input [8:0] lo;
    input [8:0] hi;
    begin
      fn_lim = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [6:0] ctrl; // Order bits, mode, standby
  reg [8:0] org_x; // Crop column origin as written
  reg [8:0] org_y; // Crop row origin as written
  reg [6:0] blk; // Shift, band, correction mode
  reg [9:0] ext_off; // External offset, signed
  reg [7:0] gain; // Gain setting
  reg [18:0] acc; // Servo accumulator, signed
  reg [9:0] blk_avg; // Last field black average
  wire [8:0] lim_x; // Clipped column origin
  wire [8:0] lim_y; // Clipped row origin
  assign lim_x = fn_lim(org_x, `PRS_XMIN, `PRS_XMAX);
  assign lim_y = fn_lim(org_y, `PRS_YMIN, `PRS_YMAX);
  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  reg aw_full; // Write address held
  reg w_full; // Write data held
  reg [4:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_wr; // Both halves present, response free
  wire [31:0] wmask;
  wire [31:0] wnew_c;
  wire [31:0] wnew_o;
  wire [31:0] wnew_b;
  wire [31:0] wnew_g;
  wire wr_ok;
  assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full & ~s_axi_bvalid;
  assign do_wr = aw_full & w_full & ~s_axi_bvalid;
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                  {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign wnew_c = ({25'h0, ctrl} & ~wmask) | (w_data & wmask);
  assign wnew_o = ({7'h0, org_y, 7'h0, org_x} & ~wmask) | (w_data & wmask);
  assign wnew_b = ({6'h0, ext_off, 9'h0, blk} & ~wmask) | (w_data & wmask);
  assign wnew_g = ({24'h0, gain} & ~wmask) | (w_data & wmask);
  assign wr_ok = (aw_addr[4:2] <= `PRS_A_GAIN >> 2);
  // Wake from standby, or a gain change, restarts the servo
  wire wake;
  wire gain_chg;
  assign wake = do_wr && aw_addr[4:2] == `PRS_A_CTRL >> 2 &&
                ctrl[`PRS_B_STBY] && !wnew_c[`PRS_B_STBY];
  assign gain_chg = do_wr && aw_addr[4:2] == `PRS_A_GAIN >> 2 &&
                    wnew_g[7:0] != gain;
  // Captures the two write halves in either order, then commits
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 5'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl <= `PRS_CTRL_RST;
      org_x <= `PRS_XCTR;
      org_y <= `PRS_YCTR;
      blk <= `PRS_BLK_RST;
      ext_off <= 10'h000;
      gain <= `PRS_GAIN_RST;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2; // Read-only or unmapped: SLVERR
        case (aw_addr[4:2])
          `PRS_A_CTRL >> 2:
          begin
            ctrl <= wnew_c[6:0];
            // Each entry into crop mode centres the window
            if (wnew_c[5:4] == `PRS_M_CROP && ctrl[5:4] != `PRS_M_CROP)
            begin
              org_x <= `PRS_XCTR;
              org_y <= `PRS_YCTR;
            end
          end
          `PRS_A_ORIG >> 2:
          begin
            org_x <= wnew_o[8:0];
            org_y <= wnew_o[24:16];
          end
          `PRS_A_BLK >> 2:
          begin
            blk <= wnew_b[6:0];
            ext_off <= wnew_b[25:16];
          end
          `PRS_A_GAIN >> 2:
            gain <= wnew_g[7:0];
          default:
            gain <= gain; // Read-only or unmapped: no effect
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;
  // Answers one cycle after the address is taken
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr[4:2])
        `PRS_A_CTRL >> 2:
          s_axi_rdata <= {25'h0, ctrl};
        `PRS_A_ORIG >> 2:
          s_axi_rdata <= {7'h0, lim_y, 7'h0, lim_x};
        `PRS_A_BLK >> 2:
          s_axi_rdata <= {6'h0, ext_off, 9'h0, blk};
        `PRS_A_GAIN >> 2:
          s_axi_rdata <= {24'h0, gain};
        `PRS_A_STAT >> 2:
          s_axi_rdata <= {6'h0, blk_avg, 5'h0, acc[18:`PRS_FRAC]};
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2; // Unmapped: SLVERR
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  // ----------------------------------------------------------------
  // Pixel clock divider
  // ----------------------------------------------------------------
  reg [6:0] fcfg; // Ordering and mode latched per field
  reg [2:0] div_cnt;
  wire qtr; // Either quarter-size mode
  wire [2:0] div_end;
  wire tick; // Pixel rate strobe
  assign qtr = fcfg[5:4] == `PRS_M_CROP || fcfg[5:4] == `PRS_M_SUB;
  assign div_end = qtr ? `PRS_DIV_QTR : `PRS_DIV_FULL;
  assign tick = (div_cnt == div_end) & ~ctrl[`PRS_B_STBY];
  // Counts system clocks per pixel; idle in standby
  always @(posedge aclk)
  begin
    if (!aresetn || ctrl[`PRS_B_STBY])
      div_cnt <= 3'h0;
    else if (tick)
      div_cnt <= 3'h0;
    else
      div_cnt <= div_cnt + 3'h1;
  end
  // ----------------------------------------------------------------
  // Scan counters and address generation
  // ----------------------------------------------------------------
  reg [8:0] col_i; // Sequence index within a line
  reg [8:0] line_i; // Line index, black lines first
  reg [8:0] ox; // Origin latched per field
  reg [8:0] oy;
  wire [8:0] win_w;
  wire [8:0] win_h;
  wire in_blk; // Current line is a black line
  wire [8:0] vis_i; // Visible row index
  wire [8:0] ck; // Column offset after ordering
  wire [8:0] rk; // Row offset after ordering
  wire [8:0] next_col;
  wire [8:0] next_row;
  wire line_end;
  wire field_end;
  assign win_w = qtr ? `PRS_QTR_W : `PRS_FULL_W;
  assign win_h = qtr ? `PRS_QTR_H : `PRS_FULL_H;
  assign in_blk = line_i < `PRS_BLK_LINES;
  assign vis_i = line_i - `PRS_BLK_LINES;
  // Orderings stack: shuffle first, then reversal
  assign ck = fn_order(col_i, win_w, fcfg[`PRS_B_HSHUF],
                       fcfg[`PRS_B_MIRR]);
  assign rk = fn_order(vis_i, win_h, fcfg[`PRS_B_VSHUF],
                       fcfg[`PRS_B_FLIP]);
  // Origin is the top-left corner whatever the order bits
  assign next_col = (fcfg[5:4] == `PRS_M_SUB) ? `PRS_SUB_X + fn_sub(ck) :
                    ox + ck;
  assign next_row = in_blk ? line_i + 9'h001 :
                    (fcfg[5:4] == `PRS_M_SUB) ? `PRS_SUB_Y + fn_sub(rk) :
                    oy + rk;
  assign line_end = col_i == win_w - 9'h001;
  assign field_end = line_end && line_i == win_h + `PRS_BLK_LINES - 9'h001;
  // Steps through the field one pixel per tick
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      col_i <= 9'h000;
      line_i <= 9'h000;
      fcfg <= `PRS_CTRL_RST;
      ox <= `PRS_FULL_X;
      oy <= `PRS_FULL_Y;
    end
    else if (ctrl[`PRS_B_STBY])
    begin
      // Idle: order and mode are taken here, so set them before waking
      col_i <= 9'h000;
      line_i <= 9'h000;
      fcfg <= ctrl;
      ox <= (ctrl[5:4] == `PRS_M_CROP) ? lim_x : `PRS_FULL_X;
      oy <= (ctrl[5:4] == `PRS_M_CROP) ? lim_y : `PRS_FULL_Y;
    end
    else if (tick)
    begin
      col_i <= line_end ? 9'h000 : col_i + 9'h001;
      if (line_end)
        line_i <= field_end ? 9'h000 : line_i + 9'h001;
      // Settings change only at a field boundary
      if (field_end)
      begin
        fcfg <= ctrl;
        ox <= (ctrl[5:4] == `PRS_M_CROP) ? lim_x : `PRS_FULL_X;
        oy <= (ctrl[5:4] == `PRS_M_CROP) ? lim_y : `PRS_FULL_Y;
      end
    end
  end
  // ----------------------------------------------------------------
  // Array access pipeline
  // ----------------------------------------------------------------
  reg p_vis; // Previous address was a visible pixel
  reg p_samp; // Previous address feeds the servo
  reg p_sol;
  reg p_sof;
  // Issues the address, tags it for the next tick
  always @(posedge aclk)
  begin
    // Standby clears the tags so no stale pixel leaks out on waking
    if (!aresetn || ctrl[`PRS_B_STBY])
    begin
      pix_col <= 9'h000;
      pix_row <= 9'h000;
      pix_rd <= 1'b0;
      p_vis <= 1'b0;
      p_samp <= 1'b0;
      p_sol <= 1'b0;
      p_sof <= 1'b0;
    end
    else
    begin
      pix_rd <= tick;
      if (tick)
      begin
        pix_col <= next_col;
        pix_row <= next_row;
        p_vis <= ~in_blk;
        // Only the middle two of four black lines are sampled
        p_samp <= (line_i == 9'h001 || line_i == 9'h002) &&
                  col_i < `PRS_BLK_SAMP;
        p_sol <= ~in_blk && col_i == 9'h000;
        p_sof <= line_i == `PRS_BLK_LINES && col_i == 9'h000;
      end
    end
  end
  // ----------------------------------------------------------------
  // Black level servo
  // ----------------------------------------------------------------
  reg [17:0] blk_sum; // Sum of sampled black pixels
  wire [9:0] avg; // Mean over 256 samples
  wire signed [10:0] err;
  wire [10:0] err_mag;
  wire [10:0] band;
  wire signed [18:0] step;
  wire upd; // End of black lines in this field
  assign avg = blk_sum[17:8];
  assign err = $signed(`PRS_TARGET) - $signed({1'b0, avg});
  assign err_mag = err[10] ? -err : err;
  assign band = blk[4] ? `PRS_BAND_W : `PRS_BAND_N;
  assign step = $signed({{8{err[10]}}, err} <<< `PRS_FRAC) >>> blk[3:0];
  assign upd = tick && line_i == `PRS_BLK_LINES && col_i == 9'h000;
  // Plain integrator with a dead band, updated once per field
  always @(posedge aclk)
  begin
    if (!aresetn || wake || gain_chg)
    begin
      acc <= `PRS_ACC_RST;
      blk_sum <= 18'h0;
      blk_avg <= 10'h000;
    end
    else if (upd)
    begin
      blk_avg <= avg;
      blk_sum <= 18'h0;
      if (err_mag > band)
        acc <= acc + step;
    end
    else if (tick && p_samp)
      blk_sum <= blk_sum + {8'h0, pix_data};
  end
  // ----------------------------------------------------------------
  // Offset application and video output
  // ----------------------------------------------------------------
  reg [9:0] sel_off; // Signed offset added to each pixel
  wire signed [11:0] corr;
  // Chooses the offset source
  always @*
  begin
    case (blk[6:5])
      `PRS_C_INT: sel_off = acc[`PRS_FRAC+9:`PRS_FRAC];
      `PRS_C_EXT: sel_off = ext_off;
      default: sel_off = 10'h000;
    endcase
  end
  // Negative offset is the pedestal being subtracted
  assign corr = $signed({2'b00, pix_data}) +
                $signed({{2{sel_off[9]}}, sel_off});
  // Saturates the corrected code into the output range
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vid_data <= 10'h000;
      vid_valid <= 1'b0;
      vid_sol <= 1'b0;
      vid_sof <= 1'b0;
    end
    else
    begin
      vid_valid <= tick & p_vis;
      vid_sol <= tick & p_sol;
      vid_sof <= tick & p_sof;
      if (tick && p_vis)
      begin
        if (corr < 0)
          vid_data <= 10'h000;
        else if (corr > $signed(`PRS_PIX_MAX))
          vid_data <= 10'h3ff;
        else
          vid_data <= corr[9:0];
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/prs_top_sva.sv
// Port checker for the readout sequencer and its register bus.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module prs_top_sva
(
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [8:0] pix_col,
  input wire [8:0] pix_row,
  input wire pix_rd,
  input wire vid_valid,
  input wire vid_sol,
  input wire vid_sof
);
  // --------------------------------------------------------------
  // Common clocking and reset for every check
  // --------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Pixel ticks never closer than the full-size divide by four
  pix_gap_a: assert property (pix_rd |=> !pix_rd [*3])
    else $error("pixel addresses closer than four clocks");
  // Video pulses follow the same pixel rate
  vid_gap_a: assert property (vid_valid |=> !vid_valid [*3])
    else $error("video pixels closer than four clocks");
  // Each video pixel is one pixel period after its address
  vid_cause_a: assert property (vid_valid |->
    $past(pix_rd, 4) || $past(pix_rd, 8))
    else $error("video pixel without address one period before");
  // Line start marks a real pixel
  line_mark_a: assert property (vid_sol |-> vid_valid)
    else $error("line start without pixel");
  // Field start is also a line start
  field_mark_a: assert property (vid_sof |-> vid_sol)
    else $error("field start without line start");
  // Addresses stay inside the physical array
  addr_range_a: assert property (pix_rd |->
    (pix_col inside {[1:364]}) && (pix_row inside {[1:296]}))
    else $error("pixel address outside the array");
  // No new write while a response is pending
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  // No new read while read data is pending
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  // Read data one cycle after the address is taken
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
endmodule
`default_nettype wire

// ===== bench/prs_pixel_array.sv
// Pixel array model answering the sequencer's address requests.
// Assumes one clock; data is ready the cycle after pix_rd.
`timescale 1ns/1ns
`default_nettype none
module prs_pixel_array
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pix_rd,
  input wire logic [8:0] pix_col,
  input wire logic [8:0] pix_row,
  output logic [9:0] pix_data
);
  // Black rows 2 and 3 read 96, rows 1 and 4 read 0, visible rows
  // carry their own address so ordering faults show in the data
  always @(posedge aclk)
  begin
    if (!aresetn)
      pix_data <= 10'h000;
    else if (pix_rd)
    begin
      if (pix_row == 9'h002 || pix_row == 9'h003)
        pix_data <= 10'h060;
      else if (pix_row < 9'h005)
        pix_data <= 10'h000;
      else
        pix_data <= {pix_col[4:0], pix_row[4:0]};
    end
  end
endmodule
`default_nettype wire

// ===== bench/test_pixel_readout_and_black_level.sv
// Self-checking bench for the readout sequencer and black level servo.
// Assumes the pixel array model and a 100 MHz aclk.
`timescale 1ns/1ns
`default_nettype none
module test_pixel_readout_and_black_level;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata;
  wire awready, wready, bvalid, arready, rvalid, pix_rd;
  wire vid_valid, vid_sol, vid_sof;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [8:0] pix_col, pix_row;
  wire [9:0] pix_data, vid_data;
  logic [1:0] bq[$];   // Expected write responses
  logic [65:0] rq[$];  // Expected read data, mask, response
  logic [11:0] vq[$];  // Expected field start, line start, pixel
  logic [65:0] re;
  logic [8:0] c, rw;
  int miscompares, checks_done, cycles, seed, i, r, k, n, col, f;

  // 100 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  prs_top u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pix_col(pix_col), .pix_row(pix_row),
    .pix_rd(pix_rd), .pix_data(pix_data), .vid_data(vid_data),
    .vid_valid(vid_valid), .vid_sol(vid_sol), .vid_sof(vid_sof));

  prs_pixel_array u_arr (.aclk(aclk), .aresetn(aresetn),
    .pix_rd(pix_rd), .pix_col(pix_col), .pix_row(pix_row),
    .pix_data(pix_data));

  // Count one comparison and report a mismatch
  task automatic chk(input logic ok, input string m);
  begin
    checks_done++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("Error at %0t: %s", $time, m);
    end
  end
  endtask

  // Verdict and end of run
  task automatic finish_test;
  begin
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask

  // Bus write: address and data offered together, then response
  task automatic axw(input logic [4:0] a, input logic [31:0] d,
    input logic [1:0] rs);
  begin
    bq.push_back(rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bready && bvalid)
        bready <= 1'b0;
    end
    while (awvalid || wvalid || bready);
  end
  endtask

  // Bus read; the watcher compares the masked data and response
  task automatic axr(input logic [4:0] a, input logic [31:0] d,
    input logic [31:0] m, input logic [1:0] rs);
  begin
    rq.push_back({d, m, rs});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rready && rvalid)
        rready <= 1'b0;
    end
    while (arvalid || rready);
  end
  endtask

  // Origin limits for crop mode
  function automatic logic [8:0] lim(input logic [8:0] v,
    input logic [8:0] lo, input logic [8:0] hi);
    lim = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Waits, bounded, until every expected video pixel has been seen
  task automatic drain;
  begin
    n = 0;
    while (vq.size() > 0 && n < 30000)
    begin
      @(posedge aclk);
      n++;
    end
  end
  endtask

  // Watcher: takes the oldest note as each result appears; timeout
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      $display("Error at %0t: timeout", $time);
      finish_test;
    end
    else
    begin
      if (bvalid && bready && bq.size() > 0)
        chk(bresp === bq.pop_front(), "write response");
      if (rvalid && rready && rq.size() > 0)
      begin
        re = rq.pop_front();
        chk(((rdata & re[33:2]) === (re[65:34] & re[33:2]))
          && (rresp === re[1:0]), "read data or response");
      end
      if (vid_valid && vq.size() > 0)
        chk({vid_sof, vid_sol, vid_data} === vq.pop_front(), "video pixel");
    end
  end

  // Main sequence
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0;
    seed = 65452;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(5'h00, 32'h41, 32'h7f, 2'b00);
    axr(5'h08, 32'h24, 32'h7f, 2'b00);
    axr(5'h0c, 32'hf0, 32'hff, 2'b00);
    axr(5'h10, 32'h7c0, 32'h7ff, 2'b00);
    axr(5'h14, 32'h0, 32'hffffffff, 2'b10);
    axw(5'h10, 32'h0, 2'b10);
    $display("Test register defaults done");
    // Boundaries first, then odd random origins
    for (k = 0; k < 6; k++)
    begin
      c = (k == 0) ? 9'h000 : (k == 1) ? 9'h1ff : 9'($random(seed)) | 9'h001;
      rw = (k == 0) ? 9'h000 : (k == 1) ? 9'h1ff : 9'($random(seed)) | 9'h001;
      axw(5'h04, {7'h00, rw, 7'h00, c}, 2'b00);
      axr(5'h04, {7'h00, lim(rw, 9'h005, 9'h095), 7'h00, lim(c, 9'h001, 9'h0b9)}, 32'h01ff01ff, 2'b00);
    end
    axw(5'h00, 32'h51, 2'b00);
    axr(5'h04, 32'h004d005d, 32'h01ff01ff, 2'b00);
    $display("Test origin limits done");
    // First field: full size, even columns first, offset -62
    for (r = 0; r < 2; r++)
      for (i = 0; i < 356; i++)
      begin
        col = (i < 178) ? 6 + 2 * i : 5 + 2 * (i - 178);
        f = (col % 32) * 32 + 5 + r;
        vq.push_back({r == 0 && i == 0, i == 0, 10'((f >= 62) ? f - 62 : 0)});
      end
    axw(5'h00, 32'h41, 2'b00);
    axw(5'h00, 32'h01, 2'b00);
    drain;
    chk(vq.size() == 0, "video lines missing");
    $display("Test video order done");
    axr(5'h10, 32'h006007c2, 32'h03ff07ff, 2'b00);
    axw(5'h0c, 32'hf1, 2'b00);
    axr(5'h10, 32'h7c0, 32'h7ff, 2'b00);
    repeat (4) @(posedge aclk);
    $display("Test servo done");
    // Crop with mirror and flip: last window row first, columns reversed
    axw(5'h00, 32'h5a, 2'b00);
    c = 9'($random(seed)) | 9'h001;
    rw = 9'($random(seed)) | 9'h001;
    axw(5'h04, {7'h00, rw, 7'h00, c}, 2'b00);
    c = lim(c, 9'h001, 9'h0b9);
    rw = lim(rw, 9'h005, 9'h095);
    for (i = 0; i < 180; i++)
    begin
      col = c + 179 - i;
      f = (col % 32) * 32 + (rw + 147) % 32;
      vq.push_back({i == 0, i == 0, 10'((f >= 62) ? f - 62 : 0)});
    end
    axw(5'h00, 32'h1a, 2'b00);
    drain;
    chk(vq.size() == 0, "crop line missing");
    $display("Test crop order done");
    finish_test;
  end
endmodule

bind prs_top prs_top_sva u_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .pix_col(pix_col), .pix_row(pix_row), .pix_rd(pix_rd),
  .vid_valid(vid_valid), .vid_sol(vid_sol), .vid_sof(vid_sof));
`default_nettype wire
